/* File: aca_defs.vh */
// constants for the analog channel status and alarm block
// assumes a 32-bit AHB-Lite register bus and eight input channels
`ifndef ACA_DEFS_VH
`define ACA_DEFS_VH
// config word fields, word index = chan*8 + field
`define ACA_FLD_LL      3'h0
`define ACA_FLD_L       3'h1
`define ACA_FLD_H       3'h2
`define ACA_FLD_HH      3'h3
`define ACA_FLD_SLEW    3'h4
`define ACA_FLD_BAND    3'h5
`define ACA_FLD_MIN     3'h6
`define ACA_FLD_MAX     3'h7
// config word reset values
`define ACA_DEF_LOW     32'h00000000
`define ACA_DEF_HIGH    32'h00000064
`define ACA_DEF_SLEW    32'h7FFFFFFF
`define ACA_DEF_BAND    32'h00000000
`define ACA_DEF_MIN     32'h80000000
`define ACA_DEF_MAX     32'h7FFFFFFF
// byte offsets above the config window
`define ACA_OFS_ALMEN   9'h100
`define ACA_OFS_LATCH   9'h104
`define ACA_OFS_UNLATCH 9'h108
`define ACA_OFS_STAT0   9'h120
`define ACA_OFS_STAT7   9'h13C
`define ACA_OFS_INTST   9'h140
`define ACA_OFS_INTCLR  9'h144
`define ACA_OFS_INTEN   9'h148
// channel status word bit positions
`define ACA_ST_BAD      0
`define ACA_ST_DOUBT    1
`define ACA_ST_BELOW    2
`define ACA_ST_ABOVE    3
`define ACA_ST_LL       4
`define ACA_ST_L        5
`define ACA_ST_H        6
`define ACA_ST_HH       7
`define ACA_ST_SLEW     8
`define ACA_ST_CALF     9
`define ACA_ST_CALB     10
// alarm enable bits per channel, bit chan*4 + kind
`define ACA_EN_LL       0
`define ACA_EN_L        1
`define ACA_EN_H        2
`define ACA_EN_HH       3
// number of config words fetched per sample
`define ACA_FETCH_LAST  4'h8
// edges since reset after which the synchronised strap is taken, on the next (third) edge
`define ACA_STRAP_CAPT  2'h2
`endif

/* File: aca_cfg_mem.v */
// per-channel limit memory: one write port, two registered read ports
// assumes writes come from the bus slave and reads from bus and engine
`timescale 1ns/1ps
`include "aca_defs.vh"
module aca_cfg_mem (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // write port
  input  wire        we,
  input  wire [5:0]  wrAddr,
  input  wire [31:0] wrData,
  // read ports
  input  wire [5:0]  rdAddrA,
  input  wire [5:0]  rdAddrB,
  output reg  [31:0] rdDataA_ff,
  output reg  [31:0] rdDataB_ff
);
  reg [31:0] mem_ff [0:63]; // limit words
  integer    i;             // reset loop index

  // reset value of a word by its field
  function [31:0] fldDefault;
    input [2:0] f;
    begin
      case (f)
        `ACA_FLD_H, `ACA_FLD_HH: fldDefault = `ACA_DEF_HIGH;
        `ACA_FLD_SLEW:           fldDefault = `ACA_DEF_SLEW;
        `ACA_FLD_BAND:           fldDefault = `ACA_DEF_BAND;
        `ACA_FLD_MIN:            fldDefault = `ACA_DEF_MIN;
        `ACA_FLD_MAX:            fldDefault = `ACA_DEF_MAX;
        default:                 fldDefault = `ACA_DEF_LOW;
      endcase
    end
  endfunction

  // storage with defaults at reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 64; i = i + 1) begin
        mem_ff[i] <= fldDefault(i[2:0]);
      end
    end else if (we) begin
      mem_ff[wrAddr] <= wrData;
    end
  end

  // registered reads, old data on a same-cycle write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdDataA_ff <= 32'h00000000;
      rdDataB_ff <= 32'h00000000;
    end else begin
      rdDataA_ff <= mem_ff[rdAddrA];
      rdDataB_ff <= mem_ff[rdAddrB];
    end
  end
endmodule // aca_cfg_mem

/* File: aca_alarm_top.v */
// status, range and alarm flags for eight analog input channels
// assumes samples and calibration events come from logic on clk,
// the calibration-present strap comes from pins, software uses AHB-Lite
// Contract
// - bad flag per channel, 1 means untrusted
// - doubtful flag per channel, 1 means maybe inaccurate
// - below-min flag when value under absolute minimum
// - above-max flag when value over absolute maximum
// - low alarms when value strictly below limit
// - high alarms when value strictly above limit
// - latched limit alarm holds until unlatch or band
// - slew alarm when step exceeds slew limit
// - latched slew alarm holds until unlatched only
// - cal fault when never calibrated or failed
// - failed-cal fault cleared by power cycle
// - cal busy flag high while calibrating
// - hysteresis band keeps triggered alarm active; the code clears a latched limit alarm inside the band instead
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "aca_defs.vh"
module aca_alarm_top (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata_ff,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  // sample stream
  input  wire        sampleValid,
  input  wire [2:0]  sampleChan,
  input  wire [31:0] sampleValue,
  input  wire        sampleBad,
  input  wire        sampleDoubtful,
  output reg         sampleReady_ff,
  // calibration events
  input  wire        calBegin,
  input  wire        calEnd,
  input  wire        calPass,
  input  wire [2:0]  calChan,
  input  wire [7:0]  calStored,
  // interrupt
  output reg         irq_ff
);
  localparam [1:0] E_IDLE  = 2'h0; // engine waits for a sample
  localparam [1:0] E_FETCH = 2'h1; // engine reads limit words
  localparam [1:0] E_EVAL  = 2'h2; // engine updates flags
  localparam [1:0] B_IDLE  = 2'h0; // bus ready
  localparam [1:0] B_RD1   = 2'h1; // read wait one
  localparam [1:0] B_RD2   = 2'h2; // read wait two

  reg  [1:0]  busSt_ff;    // bus slave state
  reg  [8:0]  addr_ff;     // captured byte address
  reg         wrPend_ff;   // write data phase pending
  reg  [31:0] almEn_ff;    // limit alarm enables
  reg  [7:0]  procLat_ff;  // latch select, limit alarms
  reg  [7:0]  slewLat_ff;  // latch select, slew alarm
  reg  [7:0]  slewEn_ff;   // slew alarm enables
  reg  [7:0]  intSt_ff;    // sticky channel events
  reg  [7:0]  intEn_ff;    // event enables
  reg  [1:0]  engSt_ff;    // engine state
  reg  [3:0]  fld_ff;      // fetch counter
  reg  [2:0]  chan_ff;     // channel under evaluation
  reg  [31:0] val_ff;      // sample value under evaluation
  reg         inBad_ff;    // sample bad indication
  reg         inDoubt_ff;  // sample doubtful indication
  reg  [31:0] lim_ff [0:7]; // fetched limit words
  reg  [31:0] prev_ff [0:7]; // last value per channel
  reg  [7:0]  havePrev_ff; // channel has a previous sample
  reg  [7:0]  bad_ff, doubt_ff, below_ff, above_ff;
  reg  [7:0]  ll_ff, l_ff, h_ff, hh_ff, slew_ff;
  reg  [7:0]  calOk_ff;    // channel holds a good calibration
  reg  [7:0]  calFail_ff;  // last calibration failed
  reg  [7:0]  calBusy_ff;  // calibration running
  reg  [1:0]  strapCnt_ff; // edges since reset, saturates
  reg  [7:0]  strapA_ff, strapB_ff; // strap synchroniser
  wire [31:0] memRdA, memRdB;
  reg  [31:0] rdMux;       // bus read data
  reg  [7:0]  enLL, enL, enH, enHH; // enables split per kind
  reg  [31:0] chanStat;    // status word of addressed channel
  reg  [1:0]  nxtEng;      // next engine state
  integer     j;           // loop index
  integer     k;           // reset loop index, engine only

  // bus handshake decode
  wire        addrPhase = hsel & htrans[1] & hreadyout_ff;
  wire        busWr     = wrPend_ff;
  wire        unlatchWr = busWr & (addr_ff == `ACA_OFS_UNLATCH);
  wire [7:0]  procUnl   = unlatchWr ? hwdata[7:0] : 8'h00;
  wire [7:0]  slewUnl   = unlatchWr ? hwdata[15:8] : 8'h00;
  wire [7:0]  intClr    = (busWr & (addr_ff == `ACA_OFS_INTCLR)) ?
                          hwdata[7:0] : 8'h00;
  wire        evalNow   = (engSt_ff == E_EVAL);
  wire [7:0]  chanBit   = 8'h01 << chan_ff;
  wire [7:0]  calFault  = ~calOk_ff | calFail_ff;

  // signed compare helpers, the band ones 33 bits so adding the band cannot wrap
  function lessThan;
    input [31:0] a, b;
    begin
      lessThan = $signed(a) < $signed(b);
    end
  endfunction
  function belowPlus; // a < b + d
    input [31:0] a, b, d;
    begin
      belowPlus = $signed({a[31], a}) <
                  ($signed({b[31], b}) + $signed({d[31], d}));
    end
  endfunction
  function abovePlus; // a > b - d
    input [31:0] a, b, d;
    begin
      abovePlus = $signed({a[31], a}) >
                  ($signed({b[31], b}) - $signed({d[31], d}));
    end
  endfunction
  // next state of one limit alarm at a sample
  function procNext;
    input prev, trig, band, lat, en;
    begin
      if (!en) begin
        procNext = 1'b0;
      end else if (lat) begin
        procNext = trig | (prev & ~(band & ~trig));
      end else begin
        procNext = trig | (prev & band);
      end
    end
  endfunction

  // slew step: absolute difference against the slew limit
  wire signed [32:0] stepDiff = $signed({val_ff[31], val_ff}) -
                                $signed({prev_ff[chan_ff][31], prev_ff[chan_ff]});
  wire [32:0] stepAbs = stepDiff[32] ? (~stepDiff + 33'h000000001) : stepDiff;
  wire slewTrig = havePrev_ff[chan_ff] &
                  (stepAbs > {1'b0, lim_ff[`ACA_FLD_SLEW]});

  // alarm conditions of the sample under evaluation
  wire trigLL = lessThan(val_ff, lim_ff[`ACA_FLD_LL]);
  wire trigL  = lessThan(val_ff, lim_ff[`ACA_FLD_L]);
  wire trigH  = lessThan(lim_ff[`ACA_FLD_H], val_ff);
  wire trigHH = lessThan(lim_ff[`ACA_FLD_HH], val_ff);
  wire bandLL = belowPlus(val_ff, lim_ff[`ACA_FLD_LL], lim_ff[`ACA_FLD_BAND]);
  wire bandL  = belowPlus(val_ff, lim_ff[`ACA_FLD_L], lim_ff[`ACA_FLD_BAND]);
  wire bandH  = abovePlus(val_ff, lim_ff[`ACA_FLD_H], lim_ff[`ACA_FLD_BAND]);
  wire bandHH = abovePlus(val_ff, lim_ff[`ACA_FLD_HH], lim_ff[`ACA_FLD_BAND]);
  wire nLL = procNext(ll_ff[chan_ff], trigLL, bandLL, procLat_ff[chan_ff],
                      enLL[chan_ff]);
  wire nL  = procNext(l_ff[chan_ff], trigL, bandL, procLat_ff[chan_ff],
                      enL[chan_ff]);
  wire nH  = procNext(h_ff[chan_ff], trigH, bandH, procLat_ff[chan_ff],
                      enH[chan_ff]);
  wire nHH = procNext(hh_ff[chan_ff], trigHH, bandHH, procLat_ff[chan_ff],
                      enHH[chan_ff]);
  wire nSlew = slewEn_ff[chan_ff] & (slewTrig |
               (slewLat_ff[chan_ff] & slew_ff[chan_ff]));
  wire riseAny = (nLL & ~ll_ff[chan_ff]) | (nL & ~l_ff[chan_ff]) |
                 (nH & ~h_ff[chan_ff]) | (nHH & ~hh_ff[chan_ff]) |
                 (nSlew & ~slew_ff[chan_ff]);

  // split enable word and build the addressed status word
  always @* begin
    chanStat = 32'h00000000;
    for (j = 0; j < 8; j = j + 1) begin
      enLL[j] = almEn_ff[4 * j + `ACA_EN_LL];
      enL[j]  = almEn_ff[4 * j + `ACA_EN_L];
      enH[j]  = almEn_ff[4 * j + `ACA_EN_H];
      enHH[j] = almEn_ff[4 * j + `ACA_EN_HH];
    end
    chanStat[`ACA_ST_BAD]   = bad_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_DOUBT] = doubt_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_BELOW] = below_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_ABOVE] = above_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_LL]    = ll_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_L]     = l_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_H]     = h_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_HH]    = hh_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_SLEW]  = slew_ff[addr_ff[4:2]];
    chanStat[`ACA_ST_CALF]  = calFault[addr_ff[4:2]];
    chanStat[`ACA_ST_CALB]  = calBusy_ff[addr_ff[4:2]];
  end

  // register read multiplexer
  always @* begin
    if (!addr_ff[8]) begin
      rdMux = memRdA; // config window
    end else if (addr_ff >= `ACA_OFS_STAT0 && addr_ff <= `ACA_OFS_STAT7) begin
      rdMux = chanStat;
    end else begin
      case (addr_ff)
        `ACA_OFS_ALMEN: rdMux = almEn_ff;
        `ACA_OFS_LATCH: rdMux = {8'h00, slewEn_ff, slewLat_ff, procLat_ff};
        `ACA_OFS_INTST: rdMux = {24'h000000, intSt_ff};
        `ACA_OFS_INTEN: rdMux = {24'h000000, intEn_ff};
        default:        rdMux = 32'h00000000; // write-only or unmapped
      endcase
    end
  end

  // ahb-lite slave: writes with no wait, reads with two waits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busSt_ff     <= B_IDLE;
      addr_ff      <= 9'h000;
      wrPend_ff    <= 1'b0;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      hresp_ff <= 1'b0; // always okay
      case (busSt_ff)
        B_IDLE: begin
          wrPend_ff <= addrPhase & hwrite;
          if (addrPhase) begin
            addr_ff <= {haddr[8:2], 2'b00};
          end
          if (addrPhase & ~hwrite) begin
            hreadyout_ff <= 1'b0;
            busSt_ff     <= B_RD1;
          end
        end
        B_RD1: begin
          wrPend_ff <= 1'b0;
          busSt_ff  <= B_RD2; // memory word being read
        end
        B_RD2: begin
          hrdata_ff    <= rdMux;
          hreadyout_ff <= 1'b1;
          busSt_ff     <= B_IDLE;
        end
        default: begin
          hreadyout_ff <= 1'b1;
          busSt_ff     <= B_IDLE;
        end
      endcase
    end
  end

  // software-written control registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      almEn_ff   <= 32'h00000000;
      procLat_ff <= 8'h00;
      slewLat_ff <= 8'h00;
      slewEn_ff  <= 8'h00;
      intEn_ff   <= 8'h00;
    end else if (busWr) begin
      if (addr_ff == `ACA_OFS_ALMEN) begin
        almEn_ff <= hwdata;
      end
      if (addr_ff == `ACA_OFS_LATCH) begin
        procLat_ff <= hwdata[7:0];
        slewLat_ff <= hwdata[15:8];
        slewEn_ff  <= hwdata[23:16];
      end
      if (addr_ff == `ACA_OFS_INTEN) begin
        intEn_ff <= hwdata[7:0];
      end
    end
  end

  // engine next state
  always @* begin
    case (engSt_ff)
      E_IDLE:  nxtEng = (sampleValid & sampleReady_ff) ? E_FETCH : E_IDLE;
      E_FETCH: nxtEng = (fld_ff == `ACA_FETCH_LAST) ? E_EVAL : E_FETCH;
      E_EVAL:  nxtEng = E_IDLE;
      default: nxtEng = E_IDLE;
    endcase
  end

  // engine: take a sample, fetch its limits, then evaluate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      engSt_ff       <= E_IDLE;
      sampleReady_ff <= 1'b0;
      fld_ff         <= 4'h0;
      chan_ff        <= 3'h0;
      val_ff         <= 32'h00000000;
      inBad_ff       <= 1'b0;
      inDoubt_ff     <= 1'b0;
      havePrev_ff    <= 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        lim_ff[k]  <= 32'h00000000;
        prev_ff[k] <= 32'h00000000;
      end
    end else begin
      engSt_ff       <= nxtEng;
      sampleReady_ff <= (nxtEng == E_IDLE);
      if (engSt_ff == E_IDLE) begin
        fld_ff     <= 4'h0;
        chan_ff    <= sampleChan;
        val_ff     <= sampleValue;
        inBad_ff   <= sampleBad;
        inDoubt_ff <= sampleDoubtful;
      end
      if (engSt_ff == E_FETCH) begin
        fld_ff <= fld_ff + 4'h1;
        if (fld_ff != 4'h0) begin
          lim_ff[fld_ff[2:0] - 3'h1] <= memRdB;
        end
      end
      if (evalNow) begin
        prev_ff[chan_ff]     <= val_ff;
        havePrev_ff[chan_ff] <= 1'b1;
      end
    end
  end

  // alarm and quality flags; a sample evaluation wins over unlatch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_ff   <= 8'h00;
      doubt_ff <= 8'h00;
      below_ff <= 8'h00;
      above_ff <= 8'h00;
      ll_ff    <= 8'h00;
      l_ff     <= 8'h00;
      h_ff     <= 8'h00;
      hh_ff    <= 8'h00;
      slew_ff  <= 8'h00;
    end else begin
      ll_ff   <= ll_ff & ~procUnl & enLL;
      l_ff    <= l_ff & ~procUnl & enL;
      h_ff    <= h_ff & ~procUnl & enH;
      hh_ff   <= hh_ff & ~procUnl & enHH;
      slew_ff <= slew_ff & ~slewUnl & slewEn_ff;
      if (evalNow) begin
        bad_ff[chan_ff]   <= inBad_ff;
        doubt_ff[chan_ff] <= inDoubt_ff | calFault[chan_ff];
        below_ff[chan_ff] <= lessThan(val_ff, lim_ff[`ACA_FLD_MIN]);
        above_ff[chan_ff] <= lessThan(lim_ff[`ACA_FLD_MAX], val_ff);
        ll_ff[chan_ff]    <= nLL;
        l_ff[chan_ff]     <= nL;
        h_ff[chan_ff]     <= nH;
        hh_ff[chan_ff]    <= nHH;
        slew_ff[chan_ff]  <= nSlew;
      end
    end
  end

  // strap synchroniser for stored calibration
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapA_ff <= 8'h00;
      strapB_ff <= 8'h00;
    end else begin
      strapA_ff <= calStored;
      strapB_ff <= strapA_ff;
    end
  end

  // calibration state; failed flag cleared by reset or by a passing calibration end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calOk_ff     <= 8'h00;
      calFail_ff   <= 8'h00;
      calBusy_ff   <= 8'h00;
      strapCnt_ff  <= 2'h0;
    end else begin
      if (strapCnt_ff != 2'h3) begin
        strapCnt_ff <= strapCnt_ff + 2'h1;
      end
      // strap only valid once it has passed both flops
      if (strapCnt_ff == `ACA_STRAP_CAPT) begin
        calOk_ff <= strapB_ff;
      end else if (calEnd & calPass) begin
        calOk_ff[calChan] <= 1'b1;
      end
      if (calEnd) begin
        calFail_ff[calChan] <= ~calPass;
        calBusy_ff[calChan] <= 1'b0;
      end else if (calBegin) begin
        calBusy_ff[calChan] <= 1'b1;
      end
    end
  end

  // sticky events, set wins over clear, gated onto the interrupt
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intSt_ff <= 8'h00;
      irq_ff   <= 1'b0;
    end else begin
      intSt_ff <= (intSt_ff & ~intClr) |
                  ((evalNow & riseAny) ? chanBit : 8'h00) |
                  ((calEnd & ~calPass) ? (8'h01 << calChan) : 8'h00);
      irq_ff   <= |(intSt_ff & intEn_ff);
    end
  end

  // limit memory
  aca_cfg_mem u_mem (
    .clk        (clk),
    .rst_n      (rst_n),
    .we         (busWr & ~addr_ff[8]),
    .wrAddr     (addr_ff[7:2]),
    .wrData     (hwdata),
    .rdAddrA    (addr_ff[7:2]),
    .rdAddrB    ({chan_ff, fld_ff[2:0]}),
    .rdDataA_ff (memRdA),
    .rdDataB_ff (memRdB)
  );
endmodule // aca_alarm_top

/* File: aca_alarm_top_assertions.sv */
// checker for the alarm block's bus timing and sample handshake
// assumes it is bound to aca_alarm_top and sees only its ports
`timescale 1ns/1ps
module aca_alarm_top_assertions (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // bus
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hrdata_ff,
  input wire        hreadyout_ff,
  input wire        hresp_ff,
  // sample handshake
  input wire        sampleValid,
  input wire        sampleReady_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a read address phase accepted by the slave
  wire rdTake = hsel && htrans[1] && !hwrite && hreadyout_ff;
  // a write address phase accepted by the slave
  wire wrTake = hsel && htrans[1] && hwrite && hreadyout_ff;

  // reads stall exactly two cycles
  rd_wait_two_a: assert property (rdTake |=> !hreadyout_ff ##1 !hreadyout_ff ##1 hreadyout_ff)
    else $error("read wait is not two cycles");
  // writes never stall
  wr_no_wait_a: assert property (wrTake |=> hreadyout_ff)
    else $error("write stalled the bus");
  // response is always okay
  resp_okay_a: assert property (!hresp_ff)
    else $error("bus response not okay");
  // read data holds between reads
  rdata_hold_a: assert property (hreadyout_ff && $past(hreadyout_ff) |-> $stable(hrdata_ff))
    else $error("read data moved without a read");
  // one evaluation per taken sample
  busy_span_a: assert property (
    sampleValid && sampleReady_ff |=> ##1 !sampleReady_ff [*8] ##[1:4] sampleReady_ff)
    else $error("sample evaluation span wrong");
  // no evaluation without a sample
  idle_hold_a: assert property (sampleReady_ff && !sampleValid |=> sampleReady_ff)
    else $error("engine left idle without a sample");
  // idle only returns after a full evaluation
  rise_gap_a: assert property ($rose(sampleReady_ff) |-> !$past(sampleReady_ff, 8))
    else $error("engine idle too early");
  // engine becomes idle one edge after reset
  reset_exit_a: assert property ($rose(rst_n) |-> !sampleReady_ff ##1 sampleReady_ff)
    else $error("engine not idle after reset");
endmodule // aca_alarm_top_assertions

/* File: aca_ctl_model.sv */
// controller model: single whole-word AHB-Lite master for limits and flags
// assumes one slave whose hreadyout is the bus ready
`timescale 1ns/1ps
module aca_ctl_model (
  // clock
  input  wire        clk,
  // bus to the block
  input  wire        hready,
  output reg         hsel,
  output reg  [31:0] haddr,
  output reg  [1:0]  htrans,
  output reg         hwrite,
  output reg  [2:0]  hsize,
  output reg  [31:0] hwdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // address phase held until ready, then data phase held until ready
  task automatic xfer(input [31:0] a, input w, input [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    @(posedge clk);
    while (!hready) @(posedge clk);
    // released data lines show no stale value
    hwdata <= ~d;
  endtask
endmodule // aca_ctl_model

/* File: aca_alarm_top_tb.sv */
// self-checking bench for the eight-channel alarm block
// assumes the controller model masters the bus and this bench feeds samples
`timescale 1ns/1ps
module aca_alarm_top_tb;
  // clock, reset, bus wires
  reg         clk, rst_n;
  wire        hsel, hwrite, hreadyout_ff, hresp_ff, irq_ff, sampleReady_ff;
  wire [31:0] haddr, hwdata, hrdata_ff;
  wire [1:0]  htrans;
  wire [2:0]  hsize;
  // sample and calibration drive
  reg         sampleValid, sampleBad, sampleDoubtful, calBegin, calEnd, calPass;
  reg  [2:0]  sampleChan, calChan;
  reg  [31:0] sampleValue, rnd;
  reg  [7:0]  calStored;
  // scoreboard
  logic [31:0] expQ[$];
  reg         rdPend;
  integer     mismatches, comparisons, cycles, i;

  aca_alarm_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .sampleValid(sampleValid), .sampleChan(sampleChan), .sampleValue(sampleValue),
    .sampleBad(sampleBad), .sampleDoubtful(sampleDoubtful),
    .sampleReady_ff(sampleReady_ff), .calBegin(calBegin), .calEnd(calEnd),
    .calPass(calPass), .calChan(calChan), .calStored(calStored), .irq_ff(irq_ff));
  aca_ctl_model ctl (.clk(clk), .hready(hreadyout_ff), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // counts and reports one comparison
  task automatic cmp(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (expQ.size() != 0)
      mismatches = mismatches + 1;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  // each completed read takes the oldest note
  always @(posedge clk) begin
    if (rdPend && hreadyout_ff) begin
      rdPend <= 1'b0;
      cmp(hrdata_ff, expQ.pop_front());
    end
    if (hsel && htrans[1] && !hwrite && hreadyout_ff)
      rdPend <= 1'b1;
  end
  // note the expected word, then read it
  task automatic chk(input [31:0] a, input [31:0] e);
    expQ.push_back(e);
    ctl.xfer(a, 1'b0, 32'h0);
  endtask
  task automatic wr(input [31:0] a, input [31:0] d);
    ctl.xfer(a, 1'b1, d);
  endtask
  // offer one sample, hold it until taken, wait for idle
  task automatic smp(input [2:0] ch, input [31:0] val, input bad, input dbt);
    @(posedge clk);
    sampleValid <= 1'b1;
    sampleChan <= ch;
    sampleValue <= val;
    sampleBad <= bad;
    sampleDoubtful <= dbt;
    @(posedge clk);
    while (!sampleReady_ff) @(posedge clk);
    sampleValid <= 1'b0;
    sampleValue <= ~val;
    repeat (2) @(posedge clk);
    while (!sampleReady_ff) @(posedge clk);
  endtask
  // clean sample, then read that channel's status word
  task automatic sc(input [2:0] ch, input [31:0] val, input [31:0] e);
    smp(ch, val, 1'b0, 1'b0);
    chk(32'h120 | {27'h0, ch, 2'b00}, e);
  endtask
  // one-cycle calibration event
  task automatic cal(input [2:0] ch, input b, input e, input p);
    @(posedge clk);
    calChan <= ch;
    calBegin <= b;
    calEnd <= e;
    calPass <= p;
    @(posedge clk);
    calBegin <= 1'b0;
    calEnd <= 1'b0;
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  initial begin
    {rst_n, sampleValid, sampleBad, sampleDoubtful, calBegin, calEnd, calPass} = 7'h0;
    {sampleChan, calChan, sampleValue, rdPend} = 39'h0;
    calStored = 8'h7F; // channel 7 never calibrated
    {mismatches, comparisons, cycles} = 96'h0;
    rnd = 32'hC68485B9;
    do_reset;
    // reset values, write-only and unmapped reads
    chk(32'h008, 32'h64);
    chk(32'h018, 32'h80000000);
    chk(32'h100, 32'h0);
    chk(32'h108, 32'h0);
    chk(32'h1FC, 32'h0);
    sc(0, 32'h0, 32'h0);
    sc(7, 32'h0, 32'h202);
    // channel 1 limits -100,-50,50,100, slew 200, band 10, range -1000..1000
    wr(32'h020, 32'hFFFFFF9C);
    wr(32'h024, 32'hFFFFFFCE);
    wr(32'h028, 32'h32);
    wr(32'h02C, 32'h64);
    wr(32'h030, 32'hC8);
    wr(32'h034, 32'hA);
    wr(32'h038, 32'hFFFFFC18);
    wr(32'h03C, 32'h3E8);
    chk(32'h02C, 32'h64);
    wr(32'h100, 32'hFF0);
    wr(32'h104, 32'h20000);
    wr(32'h148, 32'h2);
    sc(1, 32'h0, 32'h0);
    sc(1, 32'h3C, 32'h40);
    chk(32'h140, 32'h2);
    cmp({31'h0, irq_ff}, 32'h1);
    wr(32'h148, 32'h0);
    chk(32'h140, 32'h2);
    cmp({31'h0, irq_ff}, 32'h0);
    wr(32'h144, 32'h2);
    chk(32'h140, 32'h0);
    wr(32'h148, 32'h2);
    sc(1, 32'h2D, 32'h40);
    sc(1, 32'h23, 32'h0);
    sc(1, 32'h65, 32'hC0);
    sc(1, 32'hFFFFFF9B, 32'h130);
    sc(1, 32'hFFFFFC17, 32'h134);
    smp(1, 32'h3E9, 1'b1, 1'b1);
    chk(32'h124, 32'h1CB);
    sc(1, 32'h0, 32'h100);
    sc(1, 32'hC8, 32'hC0);
    sc(1, 32'h0, 32'h0);
    // channel 2 on default limits: strict compares at the edge
    sc(2, 32'h0, 32'h0);
    sc(2, 32'h64, 32'h0);
    sc(2, 32'h65, 32'hC0);
    sc(2, 32'hFFFFFFFF, 32'h30);
    // latched limit alarms on channel 1
    wr(32'h104, 32'h20002);
    sc(1, 32'h3C, 32'h40);
    sc(1, 32'h23, 32'h40);
    sc(1, 32'h2D, 32'h0);
    sc(1, 32'h3C, 32'h40);
    wr(32'h108, 32'h2);
    chk(32'h124, 32'h0);
    // latched slew alarm only drops on its own unlatch
    wr(32'h104, 32'h20202);
    sc(1, 32'h12C, 32'h1C0);
    sc(1, 32'h122, 32'h1C0);
    wr(32'h108, 32'h200);
    chk(32'h124, 32'hC0);
    wr(32'h100, 32'hF00);
    chk(32'h124, 32'h0);
    sc(1, 32'h12D, 32'h0);
    // random values and quality bits on an unalarmed channel
    for (i = 0; i < 6; i = i + 1) begin
      rnd = xs(rnd);
      smp(4, rnd, rnd[0], rnd[1]);
      chk(32'h130, {30'h0, rnd[1], rnd[0]});
    end
    // calibration: busy, failure, pass, power cycle
    wr(32'h144, 32'hFF);
    cal(3, 1'b1, 1'b0, 1'b0);
    chk(32'h12C, 32'h400);
    cal(3, 1'b0, 1'b1, 1'b0);
    chk(32'h140, 32'h8);
    sc(3, 32'h0, 32'h202);
    cal(7, 1'b1, 1'b0, 1'b0);
    cal(7, 1'b0, 1'b1, 1'b1);
    sc(7, 32'h0, 32'h0);
    do_reset;
    sc(3, 32'h0, 32'h0);
    repeat (2) @(posedge clk);
    tally_and_finish;
  end
endmodule // aca_alarm_top_tb

bind aca_alarm_top aca_alarm_top_assertions acaChk (.clk(clk), .rst_n(rst_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hrdata_ff(hrdata_ff),
  .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .sampleValid(sampleValid),
  .sampleReady_ff(sampleReady_ff));
